// ### common/dtcm_pkg.sv
// shared constants and types for the dual 8-bit timer/counter block
// assumes a 32-bit apb slave port and a single pclk domain
`default_nettype none

package dtcm_pkg;

    // ********************************************************
    // register map (byte addresses on the apb port)
    // ********************************************************
    localparam int unsigned ADDR_W    = 8;
    localparam logic [7:0]  OFS_CTRL  = 8'h00; // channel_control_reg, lower then upper
    localparam logic [7:0]  OFS_CMP   = 8'h08; // compare_period_reg, lower then upper
    localparam logic [7:0]  OFS_DUTY  = 8'h10; // pwm_duty_reg, lower then upper
    localparam logic [7:0]  CH_STRIDE = 8'h04; // distance between the two channels
    localparam logic [7:0]  OFS_CFG   = 8'h18; // prescaler source select
    localparam logic [7:0]  OFS_STAT  = 8'h1C; // counters and output flip-flops

    // ********************************************************
    // field positions and reset values
    // ********************************************************
    localparam int unsigned CTRL_TFF_POS = 7;
    localparam int unsigned CTRL_RUN_POS = 3;
    localparam int unsigned CFG_PSS_POS  = 0;
    localparam int unsigned STAT_FF_POS  = 16;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [7:0]  CMP_RST      = 8'hFF;
    localparam logic [7:0]  DUTY_RST     = 8'h80;
    localparam logic        CFG_PSS_RST  = 1'b0;
    localparam logic [7:0]  CNT_MAX      = 8'hFF;

    // ********************************************************
    // prescaler taps of the main oscillator (pclk) and sub oscillator
    // ********************************************************
    localparam int unsigned PRESC_W  = 11;
    localparam int unsigned TAP_11   = 11;
    localparam int unsigned TAP_7    = 7;
    localparam int unsigned TAP_5    = 5;
    localparam int unsigned TAP_3    = 3;
    localparam int unsigned FS_DIV_W = 3;

    // ********************************************************
    // operating modes and source clocks
    // ********************************************************
    typedef enum logic [2:0] {
        MODE_TMR    = 3'h0, // 8-bit timer, or event counter with pin source
        MODE_PDO    = 3'h1,
        MODE_PWM    = 3'h2,
        MODE_C16_LO = 3'h3, // lower half of the cascaded 16-bit timer
        MODE_C16_UP = 3'h4  // upper half, owns run bit and interrupt
    } dtcm_mode_e;

    typedef enum logic [2:0] {
        CK_SLOW = 3'h0, // main/2^11, or sub/2^3 when prescaler source select is set
        CK_D7   = 3'h1,
        CK_D5   = 3'h2,
        CK_D3   = 3'h3,
        CK_SUB  = 3'h4,
        CK_D1   = 3'h5,
        CK_MAIN = 3'h6,
        CK_PIN  = 3'h7  // falling edges on the event input pin
    } dtcm_clk_e;

    typedef struct packed {
        logic       tff;     // flipflop_init_bit
        dtcm_clk_e  clk_sel;
        logic       run;
        dtcm_mode_e mode;
    } dtcm_ctrl_s;

endpackage

`default_nettype wire

// ### logic/dtcm_core.sv
// two 8-bit up-counters with event, divider and pwm modes, cascadable to 16 bits
// assumes apb master on pclk; pins and sub oscillator are asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R01 - event mode counts falling edges on pin
// R02 - event match raises irq, clears, keeps counting
// R03 - source holds each level two cycles
// R04 - software keeps flipflop bit zero in timer
// R05 - compare period write acts immediately, unbuffered
// R06 - divider mode toggles flop, clears, raises irq
// R07 - divider pin inverts flop; preload; reset zero
// R08 - software sets port latch before output use
// R09 - stopped pin holds; preload only after stop
// R10 - bit3 runs counter, bit7 is flop preload
// R11 - 00010001B divider stopped, 00011001B running
// R12 - pwm period is full 8-bit wrap
// R13 - pwm toggles at duty, again at overflow
// R14 - pwm pin inverts flop; preload; reset zero
// R15 - pwm duty double buffered, loads at irq
// R16 - duty read returns staging value
// R17 - software writes duty right after irq
// R18 - software stops pwm before oscillator stop
// R19 - cascaded 16-bit timer, upper run and irq
// R20 - software writes lower byte, then upper
// R21 - 13H lower, 04H/0CH upper select cascade
// R22 - cascade clock from lower clock select
// R23 - event pin synchronised, falling edge compared
module dtcm_core
    import dtcm_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [1:0]        event_input_pin,
    input  wire logic              sub_osc_clock,
    output logic      [1:0]        divider_out_pin_n,
    output logic      [1:0]        pwm_out_pin_n,
    output logic      [1:0]        channel_match_irq
);

    // ********************************************************
    // declarations
    // ********************************************************
    logic [PRESC_W-1:0]  presc_q;
    logic                fs_meta_q;
    logic                fs_sync_q;
    logic                fs_prev_q;
    logic [FS_DIV_W-1:0] fs_div_q;
    logic                fs_tick;
    logic                fs8_tick;
    logic                slow_tick;
    logic                pss_q;
    logic                pready_q;
    logic                pslverr_q;
    logic [31:0]         prdata_q;
    logic [31:0]         rd_d;
    logic                mapped;
    logic                acc;
    logic                wr;
    logic                casc;
    logic [15:0]         inc16;
    logic                match16;
    dtcm_ctrl_s          ctrl_q      [2];
    logic [7:0]          cmp_q       [2];
    logic [7:0]          duty_stg_q  [2];
    logic [7:0]          duty_act_q  [2];
    logic [7:0]          cnt_q       [2];
    logic                ff_q        [2];
    logic                irq_q       [2];
    logic                div_pin_q   [2];
    logic                pwm_pin_q   [2];
    logic                ev_meta_q   [2];
    logic                ev_sync_q   [2];
    logic                ev_prev_q   [2];
    logic                ev_fall     [2];
    logic                src_tick    [2];
    logic                step        [2];
    logic                match_ev    [2];
    logic                pwm_hit     [2];
    logic                wr_ctrl     [2];
    logic                wr_cmp      [2];
    logic                wr_duty     [2];

    // ********************************************************
    // prescaler and sub oscillator
    // ********************************************************
    // free running divider of pclk; each tap is a one-cycle enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc_q <= '0;
        else
            presc_q <= presc_q + 1'b1;
    end

    // sub oscillator is asynchronous: two flops, then edge detect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fs_meta_q <= 1'b0;
            fs_sync_q <= 1'b0;
            fs_prev_q <= 1'b0;
        end
        else
        begin
            fs_meta_q <= sub_osc_clock;
            fs_sync_q <= fs_meta_q;
            fs_prev_q <= fs_sync_q;
        end
    end

    assign fs_tick = fs_sync_q & ~fs_prev_q;

    // divide the sub oscillator by eight for the slowest tap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fs_div_q <= '0;
        else if (fs_tick)
            fs_div_q <= fs_div_q + 1'b1;
    end

    assign fs8_tick  = fs_tick & (&fs_div_q);
    assign slow_tick = pss_q ? fs8_tick : (&presc_q[TAP_11-1:0]);

    // ********************************************************
    // apb slave, one wait state so that read data is registered
    // ********************************************************
    assign acc = psel & penable & pready_q;
    assign wr  = acc & pwrite;

    always_comb
    begin
        mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STAT);
        rd_d   = '0;
        if (paddr == OFS_CTRL)                rd_d[7:0] = ctrl_q[0];
        if (paddr == OFS_CTRL + CH_STRIDE)    rd_d[7:0] = ctrl_q[1];
        if (paddr == OFS_CMP)                 rd_d[7:0] = cmp_q[0];
        if (paddr == OFS_CMP + CH_STRIDE)     rd_d[7:0] = cmp_q[1];
        if (paddr == OFS_DUTY)                rd_d[7:0] = duty_stg_q[0]; // R16
        if (paddr == OFS_DUTY + CH_STRIDE)    rd_d[7:0] = duty_stg_q[1]; // R16
        if (paddr == OFS_CFG)                 rd_d[CFG_PSS_POS] = pss_q;
        if (paddr == OFS_STAT)
        begin
            rd_d[15:0]          = {cnt_q[1], cnt_q[0]};
            rd_d[STAT_FF_POS]   = ff_q[0];
            rd_d[STAT_FF_POS+1] = ff_q[1];
        end
    end

    // pready rises in the second access cycle; data and error land with it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else
        begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~mapped;
            if (psel & penable & ~pready_q)
                prdata_q <= pwrite ? '0 : rd_d;
        end
    end

    // prescaler source select; unmapped writes fall through untouched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pss_q <= CFG_PSS_RST;
        else if (wr && paddr == OFS_CFG)
            pss_q <= pwdata[CFG_PSS_POS];
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ********************************************************
    // cascade: upper channel in 16-bit mode pulls the lower along
    // ********************************************************
    assign casc    = (ctrl_q[1].mode == MODE_C16_UP); // R19 R21
    assign inc16   = {cnt_q[1], cnt_q[0]} + 16'h0001;
    assign match16 = (inc16 == {cmp_q[1], cmp_q[0]}); // R19

    // ********************************************************
    // per-channel counter, flip-flop, duty buffer and pins
    // ********************************************************
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
        localparam logic [7:0] CH_OFS = 8'(i * CH_STRIDE);

        assign wr_ctrl[i] = wr && (paddr == OFS_CTRL + CH_OFS);
        assign wr_cmp[i]  = wr && (paddr == OFS_CMP + CH_OFS);
        assign wr_duty[i] = wr && (paddr == OFS_DUTY + CH_OFS);

        // event pin: first flop feeds only the second
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                ev_meta_q[i] <= 1'b1;
                ev_sync_q[i] <= 1'b1;
                ev_prev_q[i] <= 1'b1;
            end
            else
            begin
                ev_meta_q[i] <= event_input_pin[i]; // R23
                ev_sync_q[i] <= ev_meta_q[i];
                ev_prev_q[i] <= ev_sync_q[i];
            end
        end

        // pulses narrower than two cycles may be missed by the sampler
        assign ev_fall[i] = ev_prev_q[i] & ~ev_sync_q[i]; // R23 R03

        // source clock enable chosen by the clock-select field
        always_comb
        begin
            unique case (ctrl_q[i].clk_sel)
                CK_SLOW: src_tick[i] = slow_tick;
                CK_D7:   src_tick[i] = &presc_q[TAP_7-1:0]; // R11
                CK_D5:   src_tick[i] = &presc_q[TAP_5-1:0];
                CK_D3:   src_tick[i] = &presc_q[TAP_3-1:0];
                CK_SUB:  src_tick[i] = fs_tick;
                CK_D1:   src_tick[i] = presc_q[0];
                CK_MAIN: src_tick[i] = 1'b1;
                CK_PIN:  src_tick[i] = ev_fall[i]; // R01
            endcase
        end

        // in cascade both halves step on the lower source and upper run bit
        assign step[i] = casc ? (src_tick[0] & ctrl_q[1].run)   // R22 R19
                              : (src_tick[i] & ctrl_q[i].run);  // R10

        // end-of-period event for this channel
        always_comb
        begin
            if (casc)
                match_ev[i] = (i == 1) && step[i] && match16; // R19
            else if (ctrl_q[i].mode == MODE_PWM)
                match_ev[i] = step[i] && (cnt_q[i] == CNT_MAX); // R12 R13
            else
                match_ev[i] = step[i] && (8'(cnt_q[i] + 8'h01) == cmp_q[i]); // R02 R06
        end

        assign pwm_hit[i] = !casc && (ctrl_q[i].mode == MODE_PWM) && step[i]
                            && (8'(cnt_q[i] + 8'h01) == duty_act_q[i]); // R13

        // control register; writes land whole
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                ctrl_q[i] <= CTRL_RST;
            else if (wr_ctrl[i])
                ctrl_q[i] <= pwdata[7:0]; // R10 R11 R21
        end

        // compare period has no shadow, so a write is live next cycle
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cmp_q[i] <= CMP_RST;
            else if (wr_cmp[i])
                cmp_q[i] <= pwdata[7:0]; // R05
        end

        // up-counter
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cnt_q[i] <= '0;
            else if (step[i])
            begin
                if (casc)
                    cnt_q[i] <= match16 ? 8'h00 : inc16[8*i +: 8]; // R19
                else if (ctrl_q[i].mode == MODE_PWM)
                    cnt_q[i] <= 8'(cnt_q[i] + 8'h01); // R12 R13
                else if (match_ev[i])
                    cnt_q[i] <= 8'h00; // R02 R06
                else
                    cnt_q[i] <= 8'(cnt_q[i] + 8'h01); // R01
            end
        end

        // duty staging takes every write; active copy loads at period end,
        // or at once while stopped so the first pulse is already right
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                duty_stg_q[i] <= DUTY_RST;
                duty_act_q[i] <= DUTY_RST;
            end
            else
            begin
                if (wr_duty[i])
                    duty_stg_q[i] <= pwdata[7:0]; // R15
                if (match_ev[i] || !ctrl_q[i].run)
                    duty_act_q[i] <= duty_stg_q[i]; // R15
            end
        end

        // output flip-flop: preload only while the counter was stopped,
        // so a write that stops the counter leaves the pin level alone
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                ff_q[i] <= 1'b0; // R07 R14
            else if (wr_ctrl[i] && !ctrl_q[i].run)
                ff_q[i] <= pwdata[CTRL_TFF_POS]; // R07 R09 R10 R14
            else if (casc)
                ff_q[i] <= ff_q[i];
            else if (ctrl_q[i].mode == MODE_PDO && match_ev[i])
                ff_q[i] <= ~ff_q[i]; // R06
            else if (ctrl_q[i].mode == MODE_PWM)
                ff_q[i] <= ff_q[i] ^ match_ev[i] ^ pwm_hit[i]; // R13
        end

        // registered pins and interrupt pulse
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                div_pin_q[i] <= 1'b1;
                pwm_pin_q[i] <= 1'b1;
                irq_q[i]     <= 1'b0;
            end
            else
            begin
                div_pin_q[i] <= ~ff_q[i]; // R07
                pwm_pin_q[i] <= ~ff_q[i]; // R14
                irq_q[i]     <= match_ev[i]; // R02 R06 R13 R19
            end
        end

        assign divider_out_pin_n[i] = div_pin_q[i];
        assign pwm_out_pin_n[i]     = pwm_pin_q[i];
        assign channel_match_irq[i] = irq_q[i];
    end

endmodule

`default_nettype wire

// ### verification/dtcm_pins.sv
// partner: event pulse source and passive loads on the output pins
// assumes pclk from the bench; event pins idle high as through a pull-up
`timescale 1ns/1ps
`default_nettype none

module dtcm_pins
(
    input  wire logic       pclk,
    input  wire logic [1:0] divider_out_pin_n,
    input  wire logic [1:0] pwm_out_pin_n,
    output var  logic [1:0] event_input_pin,
    output var  logic       sub_osc_clock
);
    // ********
    // sources
    // ********
    initial event_input_pin = 2'h3;
    initial sub_osc_clock = 1'b0;

    // free-running sub oscillator, unrelated in phase to pclk
    always #61 sub_osc_clock = ~sub_osc_clock;

    // each level held four cycles, twice what the counter needs
    task pulse(input int ch, input int cnt);
        repeat (cnt)
        begin
            @(posedge pclk);
            event_input_pin[ch] <= 1'b0;
            repeat (4) @(posedge pclk);
            event_input_pin[ch] <= 1'b1;
            repeat (4) @(posedge pclk);
        end
    endtask
endmodule

`default_nettype wire

// ### verification/dtcm_core_asserts.sv
// checker: apb answer timing, pin and match interrupt relations
// bound to dtcm_core below; sees that module's ports only
`timescale 1ns/1ps
`default_nettype none

module dtcm_core_chk
    import dtcm_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [1:0]        event_input_pin,
    input wire logic              sub_osc_clock,
    input wire logic [1:0]        divider_out_pin_n,
    input wire logic [1:0]        pwm_out_pin_n,
    input wire logic [1:0]        channel_match_irq
);
    // ********
    // control shadow
    // ********
    logic       wr0;
    logic [7:0] ctl0_q;

    // a write lands only at the edge that samples pready
    assign wr0 = psel && penable && pready && pwrite && paddr == OFS_CTRL;

    // lower control copy, so checks can be qualified by mode and run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl0_q <= CTRL_RST;
        else if (wr0)
            ctl0_q <= pwdata[7:0];
    end

    // ********
    // properties
    // ********
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_access_len: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("apb answer not in second access cycle");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_unmapped_err: assert property (pready && paddr > OFS_STAT |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_pins_equal: assert property (divider_out_pin_n == pwm_out_pin_n)
        else $error("divider and pwm pins differ");
    chk_reset_pins: assert property (
        $rose(presetn) |-> divider_out_pin_n == 2'h3 && channel_match_irq == 2'h0)
        else $error("pins or irq wrong after reset");
    // the lower channel, while stopped, keeps its pin unless its control word is written
    chk_stop_hold: assert property (
        !ctl0_q[CTRL_RUN_POS] && !wr0 && !$past(wr0) |=> $stable(divider_out_pin_n[0]))
        else $error("stopped pin moved");
    chk_toggle_irq: assert property (
        (ctl0_q[2:0] == MODE_PDO || ctl0_q[2:0] == MODE_PWM) && ctl0_q[CTRL_RUN_POS]
        && channel_match_irq[0] |-> ##[0:2] !$stable(divider_out_pin_n[0]))
        else $error("pin did not flip with match");
    chk_lower_quiet: assert property (ctl0_q[2:0] == MODE_C16_LO |-> !channel_match_irq[0])
        else $error("lower irq in cascade");
    chk_upper_pulse: assert property (channel_match_irq[1] |=> !channel_match_irq[1])
        else $error("upper irq wider than one cycle");

    cov_refused: cover property (pready && pslverr);
    cov_pwm: cover property (channel_match_irq[0] && ctl0_q[2:0] == MODE_PWM);
    cov_cascade: cover property (channel_match_irq[1] && ctl0_q[2:0] == MODE_C16_LO);
endmodule

bind dtcm_core dtcm_core_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_input_pin(event_input_pin),
    .sub_osc_clock(sub_osc_clock), .divider_out_pin_n(divider_out_pin_n),
    .pwm_out_pin_n(pwm_out_pin_n), .channel_match_irq(channel_match_irq));

`default_nettype wire

// ### verification/dtcm_core_tb.sv
// bench: apb tasks drive the block, the partner drives the event pins
// assumes dtcm_core, dtcm_pins and the bound checker compile first
`timescale 1ns/1ps
`default_nettype none

module dtcm_core_tb
    import dtcm_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, prdata, rdat;
    logic              pready, pslverr, rerr, sub_clk, held;
    logic [1:0]        ev_pin, pdo_n, pwm_n, irq;
    int                fails = 0, comparisons = 0, n, low;

    always #4 pclk = ~pclk;

    dtcm_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_input_pin(ev_pin), .sub_osc_clock(sub_clk),
        .divider_out_pin_n(pdo_n), .pwm_out_pin_n(pwm_n), .channel_match_irq(irq));
    dtcm_pins ext (.pclk(pclk), .divider_out_pin_n(pdo_n), .pwm_out_pin_n(pwm_n),
        .event_input_pin(ev_pin), .sub_osc_clock(sub_clk));

    // ********
    // tasks
    // ********
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp_v(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic cmp_n(input string nm, input int exp, input int got);
        comparisons++;
        if (got != exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // a wait that runs out counts as a mismatch and ends the run
    task automatic stall(input string nm);
        fails++;
        $display("CHECK FAILED %s expected answer seen none", nm);
        close_out();
    endtask

    // one transfer; request held until the edge that samples pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            stall("apb ready");
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        cmp_v(nm, exp, rdat);
    endtask

    // upper counter value from the status word
    task automatic ucnt(input logic [7:0] exp, input string nm);
        apb(1'b0, OFS_STAT, 32'h0);
        cmp_v(nm, {24'h0, exp}, {24'h0, rdat[15:8]});
    endtask

    // lower pin, a few cycles after its cause so it has settled
    task automatic pin0(input logic exp, input string nm);
        repeat (3) @(posedge pclk);
        cmp_v(nm, {31'h0, exp}, {31'h0, pdo_n[0]});
    endtask

    // cycles to the next match pulse, and pwm-low cycles among them
    task automatic span(input int ch);
        n = 0;
        low = 0;
        do
        begin
            @(posedge pclk);
            n++;
            if (pwm_n[ch] === 1'b0)
                low++;
        end
        while (irq[ch] !== 1'b1 && n < 4000);
        if (n >= 4000)
            stall("match pulse");
    endtask

    // ********
    // sequence
    // ********
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and a refused place
        rd(OFS_CTRL, 32'h0, "ctrl reset");
        rd(OFS_CMP, 32'hFF, "cmp reset");
        rd(OFS_DUTY + CH_STRIDE, 32'h80, "duty reset");
        rd(OFS_STAT, 32'h0, "status reset");
        cmp_v("pins reset", 32'hF, {28'h0, pdo_n, pwm_n});
        rd(8'h20, 32'h0, "unmapped read");
        cmp_v("unmapped error", 32'h1, {31'h0, rerr});
        wr(8'h24, 32'hFF);
        cmp_v("unmapped write error", 32'h1, {31'h0, rerr});
        wr(OFS_CFG, 32'h1);
        rd(OFS_CFG, 32'h1, "source select");
        // divider: two ticks of 128 cycles per half period
        wr(OFS_CMP, 32'h2);
        wr(OFS_CTRL, 32'h11);
        rd(OFS_CTRL, 32'h11, "divider stopped");
        pin0(1'b1, "stopped pin");
        wr(OFS_CTRL, 32'h19);
        span(0);
        span(0);
        cmp_n("divider period", 256, n);
        repeat (3) @(posedge pclk);
        held = pdo_n[0];
        span(0);
        pin0(~held, "divider toggle");
        // stop holds the pin even when the stopping write carries the other preload
        wr(OFS_CTRL, {24'h0, ~held, 7'h11});
        repeat (300) @(posedge pclk);
        pin0(~held, "pin held");
        wr(OFS_CTRL, 32'h91);
        pin0(1'b0, "preload set");
        wr(OFS_CTRL, 32'h11);
        pin0(1'b1, "preload clear");
        // pwm on pclk: duty while stopped is active at once
        wr(OFS_CTRL, 32'h62);
        wr(OFS_DUTY, 32'h40);
        rd(OFS_DUTY, 32'h40, "duty stopped");
        wr(OFS_CTRL, 32'h6A);
        span(0);
        span(0);
        cmp_n("pwm period", 256, n);
        cmp_n("pwm low", 192, low);
        wr(OFS_DUTY, 32'hC0);
        rd(OFS_DUTY, 32'hC0, "duty staging");
        span(0);
        cmp_n("old duty kept", 192, low);
        span(0);
        cmp_n("new duty low", 64, low);
        wr(OFS_CTRL, 32'h5A);
        span(0);
        span(0);
        cmp_n("pwm half rate", 512, n);
        cmp_n("pwm half rate low", 128, low);
        wr(OFS_CTRL, 32'h62);
        // upper event counter with compare 3
        wr(OFS_CMP + CH_STRIDE, 32'h3);
        wr(OFS_CTRL + CH_STRIDE, 32'h78);
        ext.pulse(1, 2);
        ucnt(8'h2, "two events");
        fork
            ext.pulse(1, 1);
            span(1);
        join
        cmp_n("event match", 1, int'(n < 12));
        ucnt(8'h0, "cleared");
        ext.pulse(1, 1);
        ucnt(8'h1, "resumed");
        // reset in mid-run clears counters and flops
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cmp_v("pins after reset", 32'hF, {28'h0, pdo_n, pwm_n});
        // cascade, compare 3, lower clock select 128 cycles
        wr(OFS_CMP, 32'h3);
        wr(OFS_CMP + CH_STRIDE, 32'h0);
        wr(OFS_CTRL, 32'h13);
        wr(OFS_CTRL + CH_STRIDE, 32'h04);
        wr(OFS_CTRL + CH_STRIDE, 32'h0C);
        span(1);
        span(1);
        cmp_n("cascade period", 384, n);
        close_out();
    end
endmodule

`default_nettype wire
